/* rtl/fpec_pkg.sv */
/*
  fpec_pkg: shared constants and types of the flash program/erase control block.
  Assumes a 32-bit classic wishbone register port, one word per register.
*/
package fpec_pkg;
  // register byte addresses
  localparam logic [3:0] ADDR_CONTROL = 4'h0;
  localparam logic [3:0] ADDR_KEY = 4'h4;
  localparam logic [3:0] ADDR_LOW = 4'h8;
  localparam logic [3:0] ADDR_HIGH = 4'hC;
  // control field positions
  localparam int BIT_START = 15;
  localparam int BIT_PERMIT = 14;
  localparam int BIT_FAULT = 13;
  localparam int BIT_IDLE_OFF = 12;
  localparam logic [15:0] CONTROL_RESET = 16'h0000;
  // unlock key bytes
  localparam logic [7:0] KEY_FIRST = 8'h55;
  localparam logic [7:0] KEY_SECOND = 8'hAA;
  // operation codes
  localparam logic [3:0] OP_DWORD = 4'h1;
  localparam logic [3:0] OP_ROW = 4'h2;
  localparam logic [3:0] OP_PAGE = 4'h3;
  localparam logic [3:0] OP_CHIP = 4'hE;
  // self-timed operation length in cycles (simulation can shorten it)
  localparam int OP_CYCLES_DEFAULT = 64;
  typedef enum logic [1:0] {OP_KIND_DWORD, OP_KIND_ROW, OP_KIND_PAGE, OP_KIND_CHIP} fpec_kind_t;
  // request handed to the flash array
  typedef struct packed {
    logic [23:0] addr;
    logic [3:0] op;
  } fpec_req_t;
endpackage

/* rtl/fpec_top.sv */
/*
  fpec_top: flash program/erase control with unlock key, control and address registers.
  Assumes a classic wishbone master, a flash array that signals completion with a
  done pulse, and a power-on reset separate from the system reset.
*/
// The placing of the registers and register access over Wishbone are this design's own decisions.
// Operation
// - key 55h then AAh arms the start
// - key register is write-only, reads zero
// - address pair gives upper byte, lower word
// - chip erase ignores the target address
// - start bit runs operation, hardware clears
// - write enable zero inhibits all operations
// - fault flag set on bad sequence/start attempt
// - fault flag zero means normal completion
// - idle power bit removes flash power idle
// - reserved and unimplemented bits read zero
// - codes 1110 chip, 0011 page erase
// - codes 0010 row, 0001 double word
// - other codes start no operation
// - control fields reset only at power-on; here the idle power bit follows the system reset
// - start refused without prior unlock
// - low address is 16-bit read/write
// - high address low byte, top reads zero
// - cpu stalled during the whole cycle
`timescale 1ns/1ps
`default_nettype none
module fpec_top #(
  parameter int OP_CYCLES = fpec_pkg::OP_CYCLES_DEFAULT
) (
  input wire logic I_CLOCK,
  input wire logic I_SYS_RST,
  input wire logic I_POR_RST,
  input wire logic I_IDLE_MODE,
  input wire logic I_FLASH_DONE,
  input wire logic I_WB_CYC,
  input wire logic I_WB_STB,
  input wire logic I_WB_WE,
  input wire logic [3:0] I_WB_ADR,
  input wire logic [3:0] I_WB_SEL,
  input wire logic [31:0] I_WB_DAT,
  output logic [31:0] O_WB_DAT,
  output logic O_WB_ACK,
  output logic O_FLASH_GO,
  output var fpec_pkg::fpec_req_t O_FLASH_REQ,
  output logic O_CPU_STALL,
  output logic O_FLASH_POWER_OFF
);
  typedef enum logic [1:0] {ST_LOCKED, ST_HALF, ST_ARMED} fpec_unlock_t;

  logic start_reg;
  logic permit_reg;
  logic fault_reg;
  logic idle_off_reg;
  logic [3:0] op_reg;
  logic [15:0] addr_low_reg;
  logic [7:0] addr_high_reg;
  fpec_unlock_t unlock_reg;
  fpec_unlock_t unlock_next;
  logic [15:0] count_reg;
  logic ack_reg;
  logic [31:0] rdata_reg;

  // op codes that name a real operation
  function automatic logic op_valid(input logic [3:0] op);
    op_valid = (op == fpec_pkg::OP_DWORD) || (op == fpec_pkg::OP_ROW) ||
      (op == fpec_pkg::OP_PAGE) || (op == fpec_pkg::OP_CHIP);
  endfunction

  // bus decode; a write takes effect in the cycle ack is raised
  wire bus_req = I_WB_CYC && I_WB_STB && !ack_reg;
  wire wr_any = bus_req && I_WB_WE;
  wire lo_lane = I_WB_SEL[0];
  wire hi_lane = I_WB_SEL[1];
  wire wr_ctrl = wr_any && (I_WB_ADR == fpec_pkg::ADDR_CONTROL);
  wire wr_key = wr_any && (I_WB_ADR == fpec_pkg::ADDR_KEY) && lo_lane;
  wire wr_low = wr_any && (I_WB_ADR == fpec_pkg::ADDR_LOW);
  wire wr_high = wr_any && (I_WB_ADR == fpec_pkg::ADDR_HIGH) && lo_lane;
  wire [7:0] key_byte = I_WB_DAT[7:0];
  wire start_try = wr_ctrl && hi_lane && I_WB_DAT[fpec_pkg::BIT_START] && !start_reg;
  // new permit value seen by the start attempt in the same write
  wire permit_now = (wr_ctrl && hi_lane) ? I_WB_DAT[fpec_pkg::BIT_PERMIT] : permit_reg;
  wire [3:0] op_now = (wr_ctrl && lo_lane) ? I_WB_DAT[3:0] : op_reg;
  wire start_ok = start_try && (unlock_reg == ST_ARMED) && permit_now && op_valid(op_now);
  wire op_done = start_reg && ((count_reg == 16'h0000) || I_FLASH_DONE);

  // unlock sequencer: any other write breaks the pair
  always_comb begin
    unlock_next = unlock_reg;
    if (wr_key) begin
      if (key_byte == fpec_pkg::KEY_FIRST) begin
        unlock_next = ST_HALF;
      end else if (key_byte == fpec_pkg::KEY_SECOND && unlock_reg == ST_HALF) begin
        unlock_next = ST_ARMED;
      end else begin
        unlock_next = ST_LOCKED;
      end
    end else if (wr_ctrl || wr_low || wr_high) begin
      // the arming is spent by the next control or address write, used or not
      unlock_next = ST_LOCKED;
    end else if (wr_any) begin
      unlock_next = ST_LOCKED;
    end
    case (unlock_next)
      ST_LOCKED, ST_HALF, ST_ARMED: ;
      default: unlock_next = ST_LOCKED;
    endcase
  end

  always_ff @(posedge I_CLOCK) begin
    if (I_SYS_RST) begin
      unlock_reg <= ST_LOCKED;
    end else begin
      unlock_reg <= unlock_next;
    end
  end

  // control fields: only power-on reset clears them
  always_ff @(posedge I_CLOCK) begin
    if (I_POR_RST) begin
      start_reg <= fpec_pkg::CONTROL_RESET[fpec_pkg::BIT_START];
      permit_reg <= fpec_pkg::CONTROL_RESET[fpec_pkg::BIT_PERMIT];
      fault_reg <= fpec_pkg::CONTROL_RESET[fpec_pkg::BIT_FAULT];
      op_reg <= fpec_pkg::CONTROL_RESET[3:0];
    end else begin
      if (wr_ctrl && hi_lane && !start_reg) begin
        permit_reg <= I_WB_DAT[fpec_pkg::BIT_PERMIT];
      end
      if (wr_ctrl && lo_lane && !start_reg) begin
        op_reg <= I_WB_DAT[3:0];
      end
      if (start_ok) begin
        start_reg <= 1'b1;
      end else if (op_done) begin
        start_reg <= 1'b0;
      end
      // any start attempt raises the flag; a clean start-to-finish clears it
      if (start_try) begin
        fault_reg <= 1'b1;
      end else if (op_done) begin
        fault_reg <= 1'b0;
      end
    end
  end

  // idle power option follows the ordinary system reset
  always_ff @(posedge I_CLOCK) begin
    if (I_SYS_RST) begin
      idle_off_reg <= 1'b0;
    end else if (wr_ctrl && hi_lane) begin
      idle_off_reg <= I_WB_DAT[fpec_pkg::BIT_IDLE_OFF];
    end
  end

  // address registers have no defined reset, they hold until written
  always_ff @(posedge I_CLOCK) begin
    if (wr_low && !start_reg) begin
      if (lo_lane) begin
        addr_low_reg[7:0] <= I_WB_DAT[7:0];
      end
      if (hi_lane) begin
        addr_low_reg[15:8] <= I_WB_DAT[15:8];
      end
    end
    if (wr_high && !start_reg) begin
      addr_high_reg <= I_WB_DAT[7:0];
    end
  end

  // self-timed countdown, cut short by the array's done pulse
  always_ff @(posedge I_CLOCK) begin
    if (I_POR_RST) begin
      count_reg <= 16'h0000;
    end else if (start_ok) begin
      count_reg <= 16'(OP_CYCLES - 1);
    end else if (start_reg && count_reg != 16'h0000) begin
      count_reg <= count_reg - 16'h0001;
    end
  end

  // read mux; reserved, unimplemented and key bits read zero
  wire [15:0] ctrl_view = {start_reg, permit_reg, fault_reg, idle_off_reg, 8'h00, op_reg};
  wire [31:0] rdata_next =
    (I_WB_ADR == fpec_pkg::ADDR_CONTROL) ? {16'h0000, ctrl_view} :
    (I_WB_ADR == fpec_pkg::ADDR_LOW) ? {16'h0000, addr_low_reg} :
    (I_WB_ADR == fpec_pkg::ADDR_HIGH) ? {24'h000000, addr_high_reg} :
    32'h00000000;

  always_ff @(posedge I_CLOCK) begin
    if (I_SYS_RST) begin
      ack_reg <= 1'b0;
      rdata_reg <= 32'h00000000;
    end else begin
      ack_reg <= bus_req;
      rdata_reg <= rdata_next;
    end
  end

  assign O_WB_ACK = ack_reg;
  assign O_WB_DAT = rdata_reg;
  assign O_FLASH_GO = start_reg;
  // chip erase hands a zero address: it never looks at the target pair
  assign O_FLASH_REQ.addr = (op_reg == fpec_pkg::OP_CHIP) ? 24'h000000 :
    {addr_high_reg, addr_low_reg};
  assign O_FLASH_REQ.op = op_reg;
  assign O_CPU_STALL = start_reg;
  assign O_FLASH_POWER_OFF = idle_off_reg && I_IDLE_MODE;

  a_start_needs_key: assert property (@(posedge I_CLOCK) disable iff (I_POR_RST)
    $rose(start_reg) |-> $past(unlock_reg) == ST_ARMED)
    else $error("start set without unlock");
  a_start_permit: assert property (@(posedge I_CLOCK) disable iff (I_POR_RST)
    $rose(start_reg) |-> permit_reg)
    else $error("start set while writes inhibited");
  a_op_valid: assert property (@(posedge I_CLOCK) disable iff (I_POR_RST)
    start_reg |-> op_valid(op_reg))
    else $error("operation running on an unused code");
  a_fault_on_try: assert property (@(posedge I_CLOCK) disable iff (I_POR_RST)
    start_try |=> fault_reg)
    else $error("fault flag not raised by start attempt");
  a_done_clears: assert property (@(posedge I_CLOCK) disable iff (I_POR_RST)
    op_done && !start_try |=> !start_reg && !fault_reg)
    else $error("completion did not clear start");
  a_stall_span: assert property (@(posedge I_CLOCK) disable iff (I_POR_RST)
    $rose(O_CPU_STALL) |-> $past(start_ok))
    else $error("stall began without an accepted start");
  a_chip_no_addr: assert property (@(posedge I_CLOCK) disable iff (I_POR_RST)
    start_reg && op_reg == fpec_pkg::OP_CHIP |-> O_FLASH_REQ.addr == 24'h000000)
    else $error("chip erase used target address");
  a_key_unread: assert property (@(posedge I_CLOCK) disable iff (I_SYS_RST)
    bus_req && !I_WB_WE && I_WB_ADR == fpec_pkg::ADDR_KEY |=> O_WB_DAT == 32'h00000000)
    else $error("key register read back nonzero");
  a_break_unlock: assert property (@(posedge I_CLOCK) disable iff (I_SYS_RST)
    wr_any && !wr_key |=> unlock_reg == ST_LOCKED)
    else $error("partial unlock survived another write");

  // unlock pair: only the two key bytes in order reach the armed state
  a_half_on_first: assert property (@(posedge I_CLOCK) disable iff (I_POR_RST || I_SYS_RST)
    wr_key && key_byte == fpec_pkg::KEY_FIRST |=> unlock_reg == ST_HALF)
    else $error("first key byte did not half-arm");
  a_armed_on_second: assert property (@(posedge I_CLOCK) disable iff (I_POR_RST || I_SYS_RST)
    wr_key && key_byte == fpec_pkg::KEY_SECOND && unlock_reg == ST_HALF |=> unlock_reg == ST_ARMED)
    else $error("second key byte did not arm");
  a_armed_from_half: assert property (@(posedge I_CLOCK) disable iff (I_POR_RST || I_SYS_RST)
    $rose(unlock_reg == ST_ARMED) |-> $past(unlock_reg) == ST_HALF)
    else $error("armed without a half step");
  a_armed_needs_key: assert property (@(posedge I_CLOCK) disable iff (I_POR_RST || I_SYS_RST)
    $rose(unlock_reg == ST_ARMED) |-> $past(wr_key) && $past(key_byte) == fpec_pkg::KEY_SECOND)
    else $error("armed without the second key byte");

  // broken pairs: a stray key or any other write throws the arming away
  a_bad_key_locks: assert property (@(posedge I_CLOCK) disable iff (I_POR_RST || I_SYS_RST)
    wr_key && key_byte != fpec_pkg::KEY_FIRST &&
    !(key_byte == fpec_pkg::KEY_SECOND && unlock_reg == ST_HALF) |=> unlock_reg == ST_LOCKED)
    else $error("wrong key byte kept the unlock");
  a_ctrl_write_locks: assert property (@(posedge I_CLOCK) disable iff (I_POR_RST || I_SYS_RST)
    wr_ctrl |=> unlock_reg == ST_LOCKED)
    else $error("control write left the unlock armed");
  a_locked_refused: assert property (@(posedge I_CLOCK) disable iff (I_POR_RST || I_SYS_RST)
    start_try && unlock_reg != ST_ARMED |=> !start_reg)
    else $error("start accepted while locked");

  // start acceptance against permit and operation code
  a_no_permit_no_go: assert property (@(posedge I_CLOCK) disable iff (I_POR_RST || I_SYS_RST)
    start_try && !permit_now |=> !start_reg)
    else $error("start accepted with writes inhibited");
  a_permit_held: assert property (@(posedge I_CLOCK) disable iff (I_POR_RST || I_SYS_RST)
    start_reg |-> permit_reg)
    else $error("operation running without permit");
  a_bad_op_refused: assert property (@(posedge I_CLOCK) disable iff (I_POR_RST || I_SYS_RST)
    start_try && !op_valid(op_now) |=> !start_reg)
    else $error("start accepted on an unused code");
  a_op_written: assert property (@(posedge I_CLOCK) disable iff (I_POR_RST || I_SYS_RST)
    wr_ctrl && lo_lane && !start_reg |=> op_reg == $past(I_WB_DAT[3:0]))
    else $error("operation select not stored");
  a_op_frozen: assert property (@(posedge I_CLOCK) disable iff (I_POR_RST || I_SYS_RST)
    wr_ctrl && start_reg |=> op_reg == $past(op_reg))
    else $error("operation select changed while running");

  // self-timed run: load, count down, clear at the end
  a_count_loaded: assert property (@(posedge I_CLOCK) disable iff (I_POR_RST || I_SYS_RST)
    start_ok |=> count_reg == 16'(OP_CYCLES - 1))
    else $error("countdown not loaded at start");
  a_count_falls: assert property (@(posedge I_CLOCK) disable iff (I_POR_RST || I_SYS_RST)
    start_reg && count_reg != 16'h0000 |=> count_reg == $past(count_reg) - 16'h0001)
    else $error("countdown did not step");
  a_start_holds: assert property (@(posedge I_CLOCK) disable iff (I_POR_RST || I_SYS_RST)
    start_reg && !op_done |=> start_reg)
    else $error("start dropped before completion");
  a_start_clears: assert property (@(posedge I_CLOCK) disable iff (I_POR_RST || I_SYS_RST)
    start_reg && op_done |=> !start_reg)
    else $error("start not cleared at completion");

  // cpu stall spans exactly the running operation
  a_stall_starts: assert property (@(posedge I_CLOCK) disable iff (I_POR_RST || I_SYS_RST)
    start_ok |=> O_CPU_STALL)
    else $error("stall missing after start");
  a_stall_bounded: assert property (@(posedge I_CLOCK) disable iff (I_POR_RST || I_SYS_RST)
    O_CPU_STALL && count_reg == 16'h0000 |=> !O_CPU_STALL)
    else $error("stall outlived the countdown");

  // sequence fault flag: set by attempts, cleared only by a clean finish
  a_fault_refused: assert property (@(posedge I_CLOCK) disable iff (I_POR_RST || I_SYS_RST)
    start_try && !start_ok |=> fault_reg && !start_reg)
    else $error("refused start did not flag a fault");
  a_fault_holds: assert property (@(posedge I_CLOCK) disable iff (I_POR_RST || I_SYS_RST)
    fault_reg && !op_done |=> fault_reg)
    else $error("fault flag lost without completion");
  a_fault_source: assert property (@(posedge I_CLOCK) disable iff (I_POR_RST || I_SYS_RST)
    $rose(fault_reg) |-> $past(start_try))
    else $error("fault flag rose without a start attempt");
  a_fault_clean_end: assert property (@(posedge I_CLOCK) disable iff (I_POR_RST || I_SYS_RST)
    $fell(start_reg) |-> !fault_reg)
    else $error("fault flag set after a normal finish");

  // target address as handed to the array
  a_addr_upper: assert property (@(posedge I_CLOCK) disable iff (I_POR_RST || I_SYS_RST)
    start_reg && op_reg != fpec_pkg::OP_CHIP |-> O_FLASH_REQ.addr[23:16] == addr_high_reg)
    else $error("upper address byte not passed on");
  a_addr_lower: assert property (@(posedge I_CLOCK) disable iff (I_POR_RST || I_SYS_RST)
    start_reg && op_reg != fpec_pkg::OP_CHIP |-> O_FLASH_REQ.addr[15:0] == addr_low_reg)
    else $error("lower address word not passed on");
  a_chip_zero_any: assert property (@(posedge I_CLOCK) disable iff (I_POR_RST || I_SYS_RST)
    op_reg == fpec_pkg::OP_CHIP |-> O_FLASH_REQ.addr == 24'h000000)
    else $error("chip erase request carries an address");
  a_low_write: assert property (@(posedge I_CLOCK) disable iff (I_POR_RST || I_SYS_RST)
    wr_low && lo_lane && hi_lane && !start_reg |=> addr_low_reg == $past(I_WB_DAT[15:0]))
    else $error("low address write not stored");
  a_high_write: assert property (@(posedge I_CLOCK) disable iff (I_POR_RST || I_SYS_RST)
    wr_high && !start_reg |=> addr_high_reg == $past(I_WB_DAT[7:0]))
    else $error("high address write not stored");

  // read views: unused bits stay zero
  a_ctrl_gap_zero: assert property (@(posedge I_CLOCK) disable iff (I_POR_RST || I_SYS_RST)
    bus_req && !I_WB_WE && I_WB_ADR == fpec_pkg::ADDR_CONTROL |=>
    O_WB_DAT[11:4] == 8'h00 && O_WB_DAT[31:16] == 16'h0000)
    else $error("reserved control bits read nonzero");
  a_low_read: assert property (@(posedge I_CLOCK) disable iff (I_POR_RST || I_SYS_RST)
    bus_req && !I_WB_WE && I_WB_ADR == fpec_pkg::ADDR_LOW |=> O_WB_DAT[31:16] == 16'h0000)
    else $error("low address read has upper bits set");
  a_high_top_zero: assert property (@(posedge I_CLOCK) disable iff (I_POR_RST || I_SYS_RST)
    bus_req && !I_WB_WE && I_WB_ADR == fpec_pkg::ADDR_HIGH |=> O_WB_DAT[31:8] == 24'h000000)
    else $error("high address unimplemented bits read nonzero");

  // idle power option
  a_power_off_on: assert property (@(posedge I_CLOCK) disable iff (I_POR_RST || I_SYS_RST)
    idle_off_reg && I_IDLE_MODE |-> O_FLASH_POWER_OFF)
    else $error("flash kept powered in idle");
  a_power_standby: assert property (@(posedge I_CLOCK) disable iff (I_POR_RST || I_SYS_RST)
    !I_IDLE_MODE |-> !O_FLASH_POWER_OFF)
    else $error("flash powered off outside idle");
  a_power_bit_zero: assert property (@(posedge I_CLOCK) disable iff (I_POR_RST || I_SYS_RST)
    !idle_off_reg |-> !O_FLASH_POWER_OFF)
    else $error("flash powered off with the option clear");

  // reset sources: only power-on touches the control fields other than the idle power bit
  a_sysrst_keeps: assert property (@(posedge I_CLOCK) disable iff (I_POR_RST)
    I_SYS_RST && !bus_req |=> op_reg == $past(op_reg) && permit_reg == $past(permit_reg))
    else $error("system reset disturbed control fields");
  a_por_clears: assert property (@(posedge I_CLOCK)
    I_POR_RST |=> !start_reg && !permit_reg && !fault_reg && op_reg == 4'h0)
    else $error("power-on reset left control fields set");

  // bus handshake: one registered ack per request
  a_ack_follows: assert property (@(posedge I_CLOCK) disable iff (I_POR_RST || I_SYS_RST)
    bus_req |=> O_WB_ACK)
    else $error("request not acknowledged");
  a_ack_single: assert property (@(posedge I_CLOCK) disable iff (I_POR_RST || I_SYS_RST)
    O_WB_ACK |=> !O_WB_ACK)
    else $error("ack held for more than one cycle");
  a_no_ack_idle: assert property (@(posedge I_CLOCK) disable iff (I_POR_RST || I_SYS_RST)
    !(I_WB_CYC && I_WB_STB) |=> !O_WB_ACK)
    else $error("ack without a request");
  a_timeout: assert property (@(posedge I_CLOCK) disable iff (I_POR_RST)
    $rose(start_reg) |-> ##[1:1000] !start_reg)
    else $error("operation never finished");
endmodule
`default_nettype wire

/* tb/testbench.sv */
/*
  testbench: self-checking bench for fpec_top over its wishbone register port.
  Assumes one registered ack a cycle after a request and OP_CYCLES set to 8.
*/
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic I_CLOCK = 1'b0, I_SYS_RST = 1'b1, I_POR_RST = 1'b1, I_IDLE_MODE = 1'b0;
  logic I_FLASH_DONE = 1'b0, I_WB_CYC = 1'b0, I_WB_STB = 1'b0, I_WB_WE = 1'b0;
  logic [3:0] I_WB_ADR = 4'h0, I_WB_SEL = 4'h0;
  logic [31:0] I_WB_DAT = 32'h0, O_WB_DAT, a;
  logic O_WB_ACK, O_FLASH_GO, O_CPU_STALL, O_FLASH_POWER_OFF;
  fpec_pkg::fpec_req_t O_FLASH_REQ;
  logic [31:0] exp_q[$];
  logic [3:0] ops[4] = '{4'h1, 4'h2, 4'h3, 4'hE};
  int n_mismatch = 0, comparisons = 0;
  fpec_top #(.OP_CYCLES(8)) dut (.I_CLOCK(I_CLOCK), .I_SYS_RST(I_SYS_RST),
    .I_POR_RST(I_POR_RST), .I_IDLE_MODE(I_IDLE_MODE), .I_FLASH_DONE(I_FLASH_DONE),
    .I_WB_CYC(I_WB_CYC), .I_WB_STB(I_WB_STB), .I_WB_WE(I_WB_WE), .I_WB_ADR(I_WB_ADR),
    .I_WB_SEL(I_WB_SEL), .I_WB_DAT(I_WB_DAT), .O_WB_DAT(O_WB_DAT), .O_WB_ACK(O_WB_ACK),
    .O_FLASH_GO(O_FLASH_GO), .O_FLASH_REQ(O_FLASH_REQ), .O_CPU_STALL(O_CPU_STALL),
    .O_FLASH_POWER_OFF(O_FLASH_POWER_OFF));
  always #2.5 I_CLOCK = ~I_CLOCK;
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic final_report();
    $display("mismatches=%0d comparisons=%0d", n_mismatch, comparisons);
    if (n_mismatch == 0 && comparisons > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // one classic cycle; values seen right after the edge are those sampled at it
  task automatic bus(input logic we, input logic [3:0] adr, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge I_CLOCK);
    {I_WB_CYC, I_WB_STB, I_WB_WE, I_WB_ADR, I_WB_SEL, I_WB_DAT} <= {2'b11, we, adr, 4'hF, d};
    do begin
      @(posedge I_CLOCK);
      n++;
    end while (O_WB_ACK !== 1'b1 && n < 50);
    if (n >= 50) begin
      n_mismatch++;
      final_report();
    end
    {I_WB_CYC, I_WB_STB} <= 2'b00;
  endtask
  task automatic wr(input logic [3:0] adr, input logic [31:0] d);
    bus(1'b1, adr, d);
  endtask
  // the expectation is queued before the request so the monitor finds it
  task automatic rd(input logic [3:0] adr, input logic [31:0] e);
    exp_q.push_back(e);
    bus(1'b0, adr, 32'h0);
  endtask
  task automatic unlock();
    wr(fpec_pkg::ADDR_KEY, {24'h0, fpec_pkg::KEY_FIRST});
    wr(fpec_pkg::ADDR_KEY, {24'h0, fpec_pkg::KEY_SECOND});
  endtask
  // read monitor: pairs every read ack with the oldest queued expectation
  always @(posedge I_CLOCK) begin
    if (O_WB_ACK === 1'b1 && I_WB_WE === 1'b0 && exp_q.size() > 0)
      check(O_WB_DAT, exp_q.pop_front());
  end
  // watchdog: fires after 20000 cycles, far more than the whole sequence needs
  initial begin
    #100000;
    n_mismatch++;
    final_report();
  end
  initial begin
    void'($urandom(26));
    repeat (12) @(posedge I_CLOCK);
    {I_SYS_RST, I_POR_RST} <= 2'b00;
    rd(fpec_pkg::ADDR_CONTROL, 32'h0);
    rd(fpec_pkg::ADDR_KEY, 32'h0);
    rd(4'h2, 32'h0);
    wr(fpec_pkg::ADDR_CONTROL, 32'hC001);
    rd(fpec_pkg::ADDR_CONTROL, 32'h6001);
    wr(fpec_pkg::ADDR_KEY, 32'h55);
    wr(fpec_pkg::ADDR_LOW, 32'h0);
    wr(fpec_pkg::ADDR_KEY, 32'hAA);
    wr(fpec_pkg::ADDR_CONTROL, 32'hC001);
    rd(fpec_pkg::ADDR_CONTROL, 32'h6001);
    unlock();
    wr(fpec_pkg::ADDR_CONTROL, 32'hC004);
    rd(fpec_pkg::ADDR_CONTROL, 32'h6004);
    unlock();
    wr(fpec_pkg::ADDR_CONTROL, 32'h8001);
    rd(fpec_pkg::ADDR_CONTROL, 32'h2001);
    check({31'h0, O_FLASH_GO}, 32'h0);
    $display("refusal tests done");
    wr(fpec_pkg::ADDR_CONTROL, 32'h1FF0);
    rd(fpec_pkg::ADDR_CONTROL, 32'h3000);
    I_IDLE_MODE <= 1'b1;
    @(negedge I_CLOCK);
    check({31'h0, O_FLASH_POWER_OFF}, 32'h1);
    I_IDLE_MODE <= 1'b0;
    $display("idle power test done");
    foreach (ops[i]) begin
      a = $urandom;
      wr(fpec_pkg::ADDR_LOW, a);
      wr(fpec_pkg::ADDR_HIGH, {16'h0, 8'hFF, a[23:16]});
      rd(fpec_pkg::ADDR_LOW, {16'h0, a[15:0]});
      rd(fpec_pkg::ADDR_HIGH, {24'h0, a[23:16]});
      wr(fpec_pkg::ADDR_CONTROL, {16'h0, 12'h400, ops[i]});
      unlock();
      wr(fpec_pkg::ADDR_CONTROL, {16'h0, 12'hC00, ops[i]});
      @(negedge I_CLOCK);
      check({30'h0, O_FLASH_GO, O_CPU_STALL}, 32'h3);
      check({4'h0, O_FLASH_REQ}, {4'h0, (ops[i] == 4'hE) ? 24'h0 : a[23:0], ops[i]});
      rd(fpec_pkg::ADDR_CONTROL, {16'h0, 12'hE00, ops[i]});
      repeat (12) @(posedge I_CLOCK);
      rd(fpec_pkg::ADDR_CONTROL, {16'h0, 12'h400, ops[i]});
      $display("operation %h done", ops[i]);
    end
    wr(fpec_pkg::ADDR_CONTROL, 32'h4003);
    I_SYS_RST <= 1'b1;
    @(posedge I_CLOCK);
    I_SYS_RST <= 1'b0;
    rd(fpec_pkg::ADDR_CONTROL, 32'h4003);
    I_POR_RST <= 1'b1;
    @(posedge I_CLOCK);
    I_POR_RST <= 1'b0;
    rd(fpec_pkg::ADDR_CONTROL, 32'h0);
    $display("reset tests done");
    repeat (2) @(posedge I_CLOCK);
    final_report();
  end
endmodule
`default_nettype wire
